/* File: verilog/slpc_top.sv */
`timescale 1ns/100ps
module slpc_top
    import slpc_pkg::*;
#(
    parameter int BLINK_CYC = slpc_pkg::SLPC_BLINK_CYC,
    parameter int BLINK_W = 23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Shared strap and LED pins
    input wire logic spi_variant_strap_i,
    output logic spi_variant_strap_o,
    output logic spi_variant_strap_oe,
    input wire logic spi_protection_strap_i,
    input wire logic port1_amplitude_strap_i,
    output logic port1_aux_led_o,
    output logic port1_aux_led_oe,
    input wire logic port1_powerdown_strap_i,
    input wire logic port2_powerdown_strap_i,
    output logic port2_link_led_o,
    output logic port2_link_led_oe,
    // Test pin 1, timestamp capture input when selected
    input wire logic test1_i,
    // LED control and timestamp pin select from software
    input wire logic [slpc_pkg::SLPC_NUM_LED-1:0] led_enable_set,
    input wire logic [slpc_pkg::SLPC_NUM_LED-1:0] led_enable_clr,
    input wire logic [slpc_pkg::SLPC_NUM_LED-1:0] led_active_low,
    input wire logic timestamp_capture_pin_select,
    // Port status
    input wire logic [1:0] link_up,
    input wire logic [1:0] activity,
    // Decoded configuration
    output slpc_pkg::slpc_host_mode_e host_mode,
    output logic host_generic_spi,
    output logic host_protect_en,
    output logic port1_amp_1v0_only,
    output logic [1:0] software_power_down,
    output logic straps_valid,
    output logic timestamp_capture_input,
    output logic [slpc_pkg::SLPC_NUM_LED-1:0] led_enabled
);
    import slpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser and pin synchronisers
    logic rst_meta_q;
    logic rst_n_q;
    logic [5:0] pins_raw;
    logic [5:0] pins_sync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    assign pins_raw = {test1_i, port2_powerdown_strap_i,
        port1_powerdown_strap_i, port1_amplitude_strap_i,
        spi_protection_strap_i, spi_variant_strap_i};

    slpc_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .clk(clk),
        .arst_n(rst_n_q),
        .clk_en(clk_en),
        .din(pins_raw),
        .dout(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap capture
    logic [SLPC_STRAP_CNT_W-1:0] wait_q;
    logic capture;
    logic latched_q;
    logic variant_q;
    logic protect_q;
    logic ampl_q;
    logic p1pd_q;
    logic p2pd_q;

    assign capture = !latched_q
        && (wait_q == SLPC_STRAP_CNT_W'(SLPC_STRAP_WAIT));

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wait_q <= '0;
        end else if (clk_en && !latched_q) begin
            wait_q <= wait_q + SLPC_STRAP_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            latched_q <= 1'b0;
            variant_q <= SLPC_VARIANT_RST;
            protect_q <= SLPC_PROTECT_RST;
            ampl_q <= SLPC_AMPL_RST;
            p1pd_q <= SLPC_P1PD_RST;
            p2pd_q <= SLPC_P2PD_RST;
        end else if (clk_en && capture) begin
            latched_q <= 1'b1;
            variant_q <= pins_sync[0];
            protect_q <= pins_sync[1];
            ampl_q <= pins_sync[2];
            p1pd_q <= pins_sync[3];
            p2pd_q <= pins_sync[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration decode
    logic [1:0] mode_sel;

    assign mode_sel = {~variant_q, protect_q};
    assign host_mode = slpc_host_mode_e'(mode_sel);
    assign host_generic_spi = variant_q;
    assign host_protect_en = protect_q;
    assign port1_amp_1v0_only = ampl_q;
    // Strap low means power-down option enabled; device still comes up active
    assign software_power_down = {~p2pd_q, ~p1pd_q};
    assign straps_valid = latched_q;

    ////////////////////////////////////////////////////////////////////////
    // Timestamp capture routing
    logic ts_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ts_q <= 1'b0;
        end else if (clk_en) begin
            ts_q <= timestamp_capture_pin_select & pins_sync[5];
        end
    end

    assign timestamp_capture_input = ts_q;

    ////////////////////////////////////////////////////////////////////////
    // LED enables
    localparam logic [SLPC_NUM_LED-1:0] LED_EN_RST =
        {SLPC_P2_LINK_EN_RST, SLPC_P1_AUX_EN_RST, SLPC_P1_LINK_EN_RST};
    logic [SLPC_NUM_LED-1:0] led_en_q;
    logic [SLPC_NUM_LED-1:0] led_en_d;

    assign led_en_d = (led_en_q & ~led_enable_clr) | led_enable_set;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            led_en_q <= LED_EN_RST;
        end else if (clk_en) begin
            led_en_q <= led_en_d;
        end
    end

    assign led_enabled = led_en_q;

    ////////////////////////////////////////////////////////////////////////
    // LED drivers, only after straps are latched
    logic [SLPC_NUM_LED-1:0] led_o;
    logic [SLPC_NUM_LED-1:0] led_oe;
    logic [SLPC_NUM_LED-1:0] led_link;
    logic [SLPC_NUM_LED-1:0] led_act;

    assign led_link = {link_up[1], link_up[0], link_up[0]};
    assign led_act = {activity[1], activity[0], activity[0]};

    genvar gi;
    generate
        for (gi = 0; gi < SLPC_NUM_LED; gi++) begin : g_led
            slpc_led_drv #(
                .BLINK_CYC(BLINK_CYC),
                .CNT_W(BLINK_W)
            ) u_led (
                .clk(clk),
                .rst_n(rst_n_q),
                .clk_en(clk_en),
                .enable(led_en_q[gi] & latched_q),
                .active_low(led_active_low[gi]),
                .link_up(led_link[gi]),
                .activity(led_act[gi]),
                .led_o(led_o[gi]),
                .led_oe(led_oe[gi])
            );
        end
    endgenerate

    assign spi_variant_strap_o = led_o[SLPC_LED_P1_LINK];
    assign spi_variant_strap_oe = led_oe[SLPC_LED_P1_LINK];
    assign port1_aux_led_o = led_o[SLPC_LED_P1_AUX];
    assign port1_aux_led_oe = led_oe[SLPC_LED_P1_AUX];
    assign port2_link_led_o = led_o[SLPC_LED_P2_LINK];
    assign port2_link_led_oe = led_oe[SLPC_LED_P2_LINK];
endmodule

/* File: verilog/slpc_pkg.sv */
package slpc_pkg;
    // Host interface variants decoded from the two straps
    typedef enum logic [1:0] {
        SLPC_HOST_GENERIC,
        SLPC_HOST_GENERIC_CRC,
        SLPC_HOST_MACPHY,
        SLPC_HOST_MACPHY_PROT
    } slpc_host_mode_e;

    // Strap reset values, matching the internal pulls
    localparam logic SLPC_VARIANT_RST = 1'b1;
    localparam logic SLPC_PROTECT_RST = 1'b1;
    localparam logic SLPC_AMPL_RST = 1'b0;
    localparam logic SLPC_P1PD_RST = 1'b0;
    localparam logic SLPC_P2PD_RST = 1'b1;

    // LED defaults
    localparam logic SLPC_P1_LINK_EN_RST = 1'b1;
    localparam logic SLPC_P1_AUX_EN_RST = 1'b0;
    localparam logic SLPC_P2_LINK_EN_RST = 1'b1;

    // Strap sample delay after internal reset release, in cycles
    localparam int unsigned SLPC_STRAP_WAIT = 4;
    localparam int SLPC_STRAP_CNT_W = 3;

    // Activity blink half-period: the LED toggles once per interval
    localparam int unsigned SLPC_BLINK_NS = 50000000;
    localparam int unsigned SLPC_CLK_NS = 10;
    localparam int unsigned SLPC_BLINK_CYC = SLPC_BLINK_NS / SLPC_CLK_NS;

    // Number of LED outputs driven by the block
    localparam int SLPC_NUM_LED = 3;
    localparam int SLPC_LED_P1_LINK = 0;
    localparam int SLPC_LED_P1_AUX = 1;
    localparam int SLPC_LED_P2_LINK = 2;
endpackage

/* File: verilog/slpc_sync.sv */
`timescale 1ns/100ps
module slpc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (clk_en) begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

/* File: verilog/slpc_led_drv.sv */
`timescale 1ns/100ps
module slpc_led_drv #(
    parameter int BLINK_CYC = 5000000,
    parameter int CNT_W = 23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Control
    input wire logic enable,
    input wire logic active_low,
    input wire logic link_up,
    input wire logic activity,
    // Pin
    output logic led_o,
    output logic led_oe
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic blink_q;
    logic blink_d;
    logic busy_q;
    logic busy_d;
    logic lit;
    logic wrap;
    logic led_q;

    assign wrap = (cnt_q == CNT_W'(BLINK_CYC - 1));
    assign cnt_d = (busy_q && !wrap) ? cnt_q + CNT_W'(1) : '0;
    assign busy_d = activity | (busy_q & ~wrap);
    assign blink_d = busy_q ? (blink_q ^ wrap) : 1'b0;
    assign lit = link_up & ~blink_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            blink_q <= 1'b0;
            busy_q <= 1'b0;
            led_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            blink_q <= blink_d;
            busy_q <= busy_d;
            led_q <= lit ^ active_low;
        end
    end

    assign led_o = led_q;
    assign led_oe = enable;
endmodule

/* File: tb/slpc_checker.sv */
`timescale 1ns/100ps
module slpc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Pins
    input wire logic spi_variant_strap_i,
    input wire logic spi_protection_strap_i,
    input wire logic port1_amplitude_strap_i,
    input wire logic port1_powerdown_strap_i,
    input wire logic port2_powerdown_strap_i,
    input wire logic spi_variant_strap_oe,
    input wire logic port1_aux_led_oe,
    input wire logic port2_link_led_oe,
    input wire logic test1_i,
    input wire logic timestamp_capture_pin_select,
    // Decoded outputs
    input wire slpc_pkg::slpc_host_mode_e host_mode,
    input wire logic host_generic_spi,
    input wire logic host_protect_en,
    input wire logic port1_amp_1v0_only,
    input wire logic [1:0] software_power_down,
    input wire logic straps_valid,
    input wire logic timestamp_capture_input,
    input wire logic [slpc_pkg::SLPC_NUM_LED-1:0] led_enabled
);
    import slpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_MODE: assert property (
        host_mode == slpc_host_mode_e'({~host_generic_spi, host_protect_en}))
        else $error("mode decode");
    AST_DFLT: assert property (
        !straps_valid |-> host_generic_spi && host_protect_en &&
        !port1_amp_1v0_only && software_power_down == 2'h1)
        else $error("defaults");
    AST_CAPT: assert property (
        $rose(straps_valid) |->
        host_generic_spi == $past(spi_variant_strap_i)
        && host_protect_en == $past(spi_protection_strap_i)
        && port1_amp_1v0_only == $past(port1_amplitude_strap_i)
        && software_power_down == ~{$past(port2_powerdown_strap_i),
        $past(port1_powerdown_strap_i)}) else $error("capture");
    AST_HOLD: assert property (
        straps_valid && $past(straps_valid) |-> $stable({host_generic_spi,
        host_protect_en, port1_amp_1v0_only, software_power_down}))
        else $error("hold");
    AST_VALID: assert property (
        $rose(arst_n) |-> !straps_valid ##[4:10] straps_valid)
        else $error("valid late");
    AST_OEGATE: assert property (
        !straps_valid |-> !(spi_variant_strap_oe || port1_aux_led_oe ||
        port2_link_led_oe)) else $error("led drive early");
    AST_TS: assert property (
        (timestamp_capture_pin_select && clk_en)[*4] |->
        timestamp_capture_input == $past(test1_i, 3)) else $error("ts");
    AST_LEDRST: assert property (
        $rose(arst_n) |-> led_enabled == 3'h5) else $error("led reset");
endmodule
bind slpc_top slpc_checker slpc_checker_i (.clk, .arst_n, .clk_en,
    .spi_variant_strap_i, .spi_protection_strap_i, .port1_amplitude_strap_i,
    .port1_powerdown_strap_i, .port2_powerdown_strap_i, .spi_variant_strap_oe,
    .port1_aux_led_oe, .port2_link_led_oe, .test1_i,
    .timestamp_capture_pin_select, .host_mode, .host_generic_spi,
    .host_protect_en, .port1_amp_1v0_only, .software_power_down,
    .straps_valid, .timestamp_capture_input, .led_enabled);

/* File: tb/slpc_strap_model.sv */
`timescale 1ns/100ps
module slpc_strap_model (
    // Board resistors: fitted and level
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_v,
    // Device drive on shared pins
    input wire logic [4:0] drv_o,
    input wire logic [4:0] drv_oe,
    // Resolved pin levels
    output logic [4:0] pin
);
    // Pulls: p2 pd up, p1 pd down, amplitude down, protect up, variant up
    localparam logic [4:0] PULL = 5'h13;
    // Device drive wins, then a fitted resistor, then the internal pull
    assign pin = (drv_oe & drv_o) | (~drv_oe & ext_en & ext_v)
        | (~drv_oe & ~ext_en & PULL);
endmodule

/* File: tb/test_strap_and_led_pin_config.sv */
`timescale 1ns/100ps
module test_strap_and_led_pin_config;
    import slpc_pkg::*;
    typedef struct packed {
        logic [4:0] en;
        logic [4:0] v;
        logic [1:0] mode;
        logic amp;
        logic [1:0] pd;
    } slpc_row_s;
    slpc_row_s rows [4] = '{'{5'h00, 5'h00, 2'h1, 1'h0, 2'h1},
        '{5'h1f, 5'h0c, 2'h2, 1'h1, 2'h2}, '{5'h01, 5'h00, 2'h3, 1'h0, 2'h1},
        '{5'h02, 5'h00, 2'h0, 1'h0, 2'h1}};
    logic clk = 0, arst_n = 0, clk_en = 1, test1_i = 1;
    logic timestamp_capture_pin_select = 0;
    logic [2:0] led_enable_set = 3'h0, led_enable_clr = 3'h0;
    logic [2:0] led_active_low = 3'h0, led_enabled;
    logic [1:0] link_up = 2'h0, activity = 2'h0, software_power_down;
    logic [4:0] ext_en = 5'h00, ext_v = 5'h00, pin;
    logic spi_variant_strap_o, spi_variant_strap_oe, port1_aux_led_o;
    logic port1_aux_led_oe, port2_link_led_o, port2_link_led_oe, last;
    logic host_generic_spi, host_protect_en, port1_amp_1v0_only;
    logic straps_valid, timestamp_capture_input;
    slpc_host_mode_e host_mode;
    int err_count = 0, check_count = 0, n = 0;
    slpc_top #(.BLINK_CYC(8), .BLINK_W(4)) slpc_top_i (.clk, .arst_n,
        .clk_en, .spi_variant_strap_i(pin[0]), .spi_variant_strap_o,
        .spi_variant_strap_oe, .spi_protection_strap_i(pin[1]),
        .port1_amplitude_strap_i(pin[2]), .port1_aux_led_o,
        .port1_aux_led_oe, .port1_powerdown_strap_i(pin[3]),
        .port2_powerdown_strap_i(pin[4]), .port2_link_led_o,
        .port2_link_led_oe, .test1_i, .led_enable_set, .led_enable_clr,
        .led_active_low, .timestamp_capture_pin_select, .link_up,
        .activity, .host_mode, .host_generic_spi, .host_protect_en,
        .port1_amp_1v0_only, .software_power_down, .straps_valid,
        .timestamp_capture_input, .led_enabled);
    slpc_strap_model slpc_strap_model_i (.ext_en, .ext_v, .pin,
        .drv_o({port2_link_led_o, 1'b0, port1_aux_led_o, 1'b0,
        spi_variant_strap_o}), .drv_oe({port2_link_led_oe, 1'b0,
        port1_aux_led_oe, 1'b0, spi_variant_strap_oe}));
    always #5 clk = ~clk;
    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task check(input logic [2:0] got, input logic [2:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task restart(input int k);
        arst_n = 0;
        step(k);
        arst_n = 1;
        for (int i = 0; i < 20 && straps_valid !== 1'b1; i++)
            step(1);
    endtask
    initial begin
        #50us;
        err_count++;
        end_of_test;
    end
    initial begin
        foreach (rows[i]) begin
            ext_en = rows[i].en;
            ext_v = rows[i].v;
            restart(i == 0 ? 12 : 3);
            check(straps_valid, 3'h1, "valid");
            check(host_mode, rows[i].mode, "mode");
            check(port1_amp_1v0_only, rows[i].amp, "amp");
            check(software_power_down, rows[i].pd, "pd");
        end
        ext_en = 5'h1f;
        ext_v = 5'h0c;
        step(5);
        check(host_mode, 3'h0, "hold");
        check(software_power_down, 3'h1, "hold");
        check(led_enabled, 3'h5, "led rst");
        clk_en = 0;
        led_enable_set = 3'h2;
        step(3);
        check(led_enabled, 3'h5, "freeze");
        clk_en = 1;
        step(2);
        check(led_enabled, 3'h7, "aux on");
        led_enable_set = 3'h0;
        led_enable_clr = 3'h7;
        step(2);
        check(led_enabled, 3'h0, "clear");
        led_enable_clr = 3'h0;
        led_enable_set = 3'h7;
        led_active_low = 3'h7;
        step(4);
        check({pin[4], pin[2], pin[0]}, 3'h7, "low pol");
        led_active_low = 3'h0;
        step(4);
        check({pin[4], pin[2], pin[0]}, 3'h0, "high pol");
        link_up = 2'h3;
        step(4);
        check({pin[4], pin[2], pin[0]}, 3'h7, "link");
        activity = 2'h3;
        for (int i = 0; i < 40; i++) begin
            last = pin[0];
            step(1);
            if (pin[0] !== last)
                n++;
        end
        check(n > 2, 3'h1, "blink");
        timestamp_capture_pin_select = 1;
        test1_i = 0;
        step(5);
        check(timestamp_capture_input, 3'h0, "ts");
        test1_i = 1;
        step(5);
        check(timestamp_capture_input, 3'h1, "ts");
        end_of_test;
    end
endmodule
